// >>> verilog/icpf_pkg.sv
// package: constants and types of the id-code prefix filter
`default_nettype none
package icpf_pkg;
  // ****************
  // sizes
  // ****************
  localparam int CHAR_W = 8;
  localparam int PREFIX_MAX = 16;
  localparam int FIELD_MAX = 40;
  localparam int CODE_MAX = 64;
  localparam int NUM_SRC = 2;
  // ****************
  // setting ranges and reset values
  // ****************
  localparam logic [4:0] PLEN_MAX = 5'h10;
  localparam logic [4:0] PLEN_RST = 5'h00;
  localparam logic [5:0] FROM_MIN = 6'h01;
  localparam logic [5:0] FROM_MAX = 6'h28;
  localparam logic [5:0] FROM_RST = 6'h01;
  localparam logic [5:0] NUM_MIN = 6'h01;
  localparam logic [5:0] NUM_MAX = 6'h28;
  localparam logic [5:0] NUM_RST = 6'h28;
  // arbitrary neutral station address, leftmost octet even
  localparam logic [47:0] FACTORY_MAC = 48'h02_00_00_00_00_01;
  // ****************
  // register map, byte addresses
  // ****************
  localparam logic [7:0] OFS_PLEN = 8'h00;
  localparam logic [7:0] OFS_PFX0 = 8'h04;
  localparam logic [7:0] OFS_PFX3 = 8'h10;
  localparam logic [7:0] OFS_FROM = 8'h14;
  localparam logic [7:0] OFS_NUM = 8'h18;
  localparam logic [7:0] OFS_BLK_END = 8'h40;
  localparam logic [7:0] OFS_MAC_HI = 8'h40;
  localparam logic [7:0] OFS_MAC_LO = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  localparam logic [7:0] OFS_CTRL = 8'h4C;
  localparam int SRC_ADDR_BIT = 5;
  localparam int CTRL_DEFAULTS_BIT = 0;
  localparam int MAC_LEAD_LSB = 16;
  // ****************
  // types
  // ****************
  typedef struct packed {
    logic src;
    logic last;
    logic [CHAR_W-1:0] chr;
  } icpf_char_t;
  typedef enum logic [1:0] {
    ST_COLLECT = 2'b01,
    ST_EVAL = 2'b10
  } icpf_state_t;
endpackage
`default_nettype wire

// >>> verilog/icpf_extract.sv
// module: prefix check, length check and substring extraction
`timescale 1ns/10ps
`default_nettype none
module icpf_extract #(
  parameter int CODE_MAX = 64,
  parameter int PREFIX_MAX = 16,
  parameter int FIELD_MAX = 40,
  parameter int LEN_W = 7
) (
  input wire logic [CODE_MAX*8-1:0] i_code,
  input wire logic [LEN_W-1:0] i_len,
  input wire logic [PREFIX_MAX*8-1:0] i_pfx,
  input wire logic [4:0] i_plen,
  input wire logic [5:0] i_from,
  input wire logic [5:0] i_num,
  output logic o_ok,
  output logic [5:0] o_cnt,
  output logic [FIELD_MAX*8-1:0] o_data
);
  logic [PREFIX_MAX-1:0] pfx_hit;
  logic len_ok;
  logic [LEN_W-1:0] avail;
  logic clip;

  // ****************
  // prefix compare, empty prefix passes everything
  // ****************
  for (genvar i = 0; i < PREFIX_MAX; i++)
  begin : g_pfx
    assign pfx_hit[i] = (5'(i) >= i_plen) ||
      ((LEN_W'(i) < i_len) && (i_code[i*8 +: 8] == i_pfx[i*8 +: 8]));
  end

  // code must reach the start position
  assign len_ok = i_len >= LEN_W'(i_from);
  assign o_ok = (&pfx_hit) && len_ok;

  // clip to the end of the code
  assign avail = LEN_W'(i_len - LEN_W'(i_from) + LEN_W'(1));
  assign clip = {1'b0, i_num} > avail;
  assign o_cnt = clip ? avail[5:0] : i_num;

  // ****************
  // per output character select
  // ****************
  for (genvar j = 0; j < FIELD_MAX; j++)
  begin : g_out
    logic [7:0] idx;
    assign idx = 8'(i_from) - 8'h01 + 8'(j);
    assign o_data[j*8 +: 8] = ((6'(j) < o_cnt) && (idx < 8'(CODE_MAX))) ?
      i_code[idx*8 +: 8] : 8'h00;
  end
endmodule // icpf_extract
`default_nettype wire

// >>> verilog/icpf_top.sv
// module: id-code prefix filter and extractor with apb settings
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - each reader keeps a prefix of zero to sixteen characters
// - an empty prefix disables the prefix check
// - a set prefix must equal the code's leading characters; shorter codes fail
// - defaults leave the prefix empty
// - start position is one-based, only 1 to 40 accepted
// - codes shorter than the start position are rejected
// - defaults set start position to one
// - extraction length only 1 to 40 accepted
// - extraction stops at the end of the code
// - defaults set extraction length to forty
// - internal and external readers have independent settings
// - the extracted substring is what gets recorded
// - station address edited as high and low three-octet halves
// - an odd leftmost address octet is refused
// - system reset restores the factory station address
module icpf_top #(
  parameter int CODE_MAX = icpf_pkg::CODE_MAX,
  parameter logic [47:0] FACTORY_MAC = icpf_pkg::FACTORY_MAC
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_CODE_VALID,
  input wire icpf_pkg::icpf_char_t I_CODE,
  output logic O_CODE_READY,
  output logic O_ACCEPT,
  output logic O_REJECT,
  output logic O_SRC,
  output logic [5:0] O_COUNT,
  output logic [icpf_pkg::FIELD_MAX*8-1:0] O_DATA,
  output logic [47:0] O_MAC
);
  localparam int LEN_W = $clog2(CODE_MAX + 1);
  // ****************
  // apb decode
  // ****************
  logic setup;
  logic acc_wr;
  logic in_blk;
  logic reg_src;
  logic [7:0] reg_ofs;
  logic addr_bad;
  logic val_bad;
  logic [31:0] rd_word;
  logic [31:0] prdata_q;
  logic err_q;
  assign setup = I_PSEL && !I_PENABLE;
  assign acc_wr = I_PSEL && I_PENABLE && I_PWRITE && !err_q;
  assign in_blk = I_PADDR < icpf_pkg::OFS_BLK_END;
  assign reg_src = I_PADDR[icpf_pkg::SRC_ADDR_BIT];
  assign reg_ofs = {3'h0, I_PADDR[4:0]};
  // zero wait states: data and error are set up in the setup cycle
  assign O_PREADY = 1'b1;
  assign O_PRDATA = prdata_q;
  assign O_PSLVERR = err_q && I_PSEL && I_PENABLE;

  // ****************
  // per-reader settings
  // ****************
  logic [4:0] plen_q [icpf_pkg::NUM_SRC];
  logic [icpf_pkg::PREFIX_MAX*8-1:0] pfx_q [icpf_pkg::NUM_SRC];
  logic [5:0] from_q [icpf_pkg::NUM_SRC];
  logic [5:0] num_q [icpf_pkg::NUM_SRC];
  logic dflt_req;
  // defaults command from the control register
  assign dflt_req = acc_wr && (I_PADDR == icpf_pkg::OFS_CTRL) &&
    I_PWDATA[icpf_pkg::CTRL_DEFAULTS_BIT];
  for (genvar s = 0; s < icpf_pkg::NUM_SRC; s++)
  begin : g_src
    logic sel;
    logic wr_plen;
    logic wr_from;
    logic wr_num;
    logic [3:0] wr_pfx;
    // each reader owns its own address block
    assign sel = acc_wr && in_blk && (reg_src == 1'(s));
    assign wr_plen = sel && (reg_ofs == icpf_pkg::OFS_PLEN);
    assign wr_from = sel && (reg_ofs == icpf_pkg::OFS_FROM);
    assign wr_num = sel && (reg_ofs == icpf_pkg::OFS_NUM);
    for (genvar w = 0; w < 4; w++)
    begin : g_w
      assign wr_pfx[w] = sel && (reg_ofs == 8'(icpf_pkg::OFS_PFX0 + 8'(4*w)));
    end
    // out-of-range values never reach these, they are refused by pslverr
    always_ff @(posedge I_SYS_CLK)
    begin
      if (I_RST || dflt_req)
      begin
        plen_q[s] <= icpf_pkg::PLEN_RST;
        from_q[s] <= icpf_pkg::FROM_RST;
        num_q[s] <= icpf_pkg::NUM_RST;
        pfx_q[s] <= '0;
      end
      else
      begin
        if (wr_plen)
          plen_q[s] <= I_PWDATA[4:0];
        if (wr_from)
          from_q[s] <= I_PWDATA[5:0];
        if (wr_num)
          num_q[s] <= I_PWDATA[5:0];
        for (int w = 0; w < 4; w++)
          if (wr_pfx[w])
            pfx_q[s][w*32 +: 32] <= I_PWDATA;
      end
    end
  end

  // ****************
  // station address
  // ****************
  logic [23:0] mac_hi_q;
  logic [23:0] mac_lo_q;
  logic wr_mac_hi;
  logic wr_mac_lo;
  assign wr_mac_hi = acc_wr && (I_PADDR == icpf_pkg::OFS_MAC_HI);
  assign wr_mac_lo = acc_wr && (I_PADDR == icpf_pkg::OFS_MAC_LO);
  assign O_MAC = {mac_hi_q, mac_lo_q};
  // halves written separately; odd lead octet refused at decode
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      mac_hi_q <= FACTORY_MAC[47:24];
      mac_lo_q <= FACTORY_MAC[23:0];
    end
    else
    begin
      if (wr_mac_hi)
        mac_hi_q <= I_PWDATA[23:0];
      if (wr_mac_lo)
        mac_lo_q <= I_PWDATA[23:0];
    end
  end
  // ****************
  // code intake
  // ****************
  icpf_pkg::icpf_state_t state_q;
  logic [CODE_MAX*8-1:0] buf_q;
  logic [LEN_W-1:0] len_q;
  logic ovf_q;
  logic src_q;
  logic take;
  logic ok;
  logic [5:0] cnt;
  logic [icpf_pkg::FIELD_MAX*8-1:0] ext;
  logic last_acc_q;
  logic last_rej_q;
  // no new characters while the finished code is evaluated
  assign O_CODE_READY = (state_q == icpf_pkg::ST_COLLECT);
  assign take = I_CODE_VALID && O_CODE_READY;
  // settings follow the source of the code
  icpf_extract #(
    .CODE_MAX(CODE_MAX),
    .PREFIX_MAX(icpf_pkg::PREFIX_MAX),
    .FIELD_MAX(icpf_pkg::FIELD_MAX),
    .LEN_W(LEN_W)
  ) u_extract (
    .i_code(buf_q),
    .i_len(len_q),
    .i_pfx(pfx_q[src_q]),
    .i_plen(plen_q[src_q]),
    .i_from(from_q[src_q]),
    .i_num(num_q[src_q]),
    .o_ok(ok),
    .o_cnt(cnt),
    .o_data(ext)
  );
  // collect characters, then one evaluation cycle
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      state_q <= icpf_pkg::ST_COLLECT;
      len_q <= '0;
      ovf_q <= 1'b0;
      src_q <= 1'b0;
      buf_q <= '0;
    end
    else
    begin
      unique case (state_q)
        icpf_pkg::ST_COLLECT:
        begin
          if (take)
          begin
            src_q <= I_CODE.src;
            // too long a code cannot be judged whole, so it is failed
            if (len_q < LEN_W'(CODE_MAX))
            begin
              buf_q[len_q*8 +: 8] <= I_CODE.chr;
              len_q <= LEN_W'(len_q + LEN_W'(1));
            end
            else
              ovf_q <= 1'b1;
            if (I_CODE.last)
              state_q <= icpf_pkg::ST_EVAL;
          end
        end
        icpf_pkg::ST_EVAL:
        begin
          len_q <= '0;
          ovf_q <= 1'b0;
          state_q <= icpf_pkg::ST_COLLECT;
        end
      endcase
    end
  end

  // result registers, pulses last one cycle
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      O_ACCEPT <= 1'b0;
      O_REJECT <= 1'b0;
      O_SRC <= 1'b0;
      O_COUNT <= 6'h00;
      O_DATA <= '0;
    end
    else
    begin
      O_ACCEPT <= (state_q == icpf_pkg::ST_EVAL) && ok && !ovf_q;
      O_REJECT <= (state_q == icpf_pkg::ST_EVAL) && !(ok && !ovf_q);
      if (state_q == icpf_pkg::ST_EVAL)
      begin
        O_SRC <= src_q;
        O_COUNT <= (ok && !ovf_q) ? cnt : 6'h00;
        O_DATA <= (ok && !ovf_q) ? ext : '0;
      end
    end
  end

  // last outcome kept for the status register
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      last_acc_q <= 1'b0;
      last_rej_q <= 1'b0;
    end
    else if (O_ACCEPT || O_REJECT)
    begin
      last_acc_q <= O_ACCEPT;
      last_rej_q <= O_REJECT;
    end
  end

  // ****************
  // read mux and refusal of bad values
  // ****************
  always_comb
  begin
    rd_word = 32'h0000_0000;
    addr_bad = 1'b0;
    val_bad = 1'b0;
    if (in_blk)
    begin
      if (reg_ofs == icpf_pkg::OFS_PLEN)
      begin
        rd_word = {27'h0, plen_q[reg_src]};
        val_bad = I_PWDATA > 32'(icpf_pkg::PLEN_MAX);
      end
      else if (reg_ofs >= icpf_pkg::OFS_PFX0 && reg_ofs <= icpf_pkg::OFS_PFX3)
        rd_word = pfx_q[reg_src][2'(reg_ofs[3:2] - 2'h1)*32 +: 32]; // word 3 wraps to index 3
      else if (reg_ofs == icpf_pkg::OFS_FROM)
      begin
        rd_word = {26'h0, from_q[reg_src]};
        val_bad = I_PWDATA < 32'(icpf_pkg::FROM_MIN) ||
          I_PWDATA > 32'(icpf_pkg::FROM_MAX);
      end
      else if (reg_ofs == icpf_pkg::OFS_NUM)
      begin
        rd_word = {26'h0, num_q[reg_src]};
        val_bad = I_PWDATA < 32'(icpf_pkg::NUM_MIN) ||
          I_PWDATA > 32'(icpf_pkg::NUM_MAX);
      end
      else
        addr_bad = 1'b1;
    end
    else if (I_PADDR == icpf_pkg::OFS_MAC_HI)
    begin
      rd_word = {8'h00, mac_hi_q};
      val_bad = I_PWDATA[icpf_pkg::MAC_LEAD_LSB];
    end
    else if (I_PADDR == icpf_pkg::OFS_MAC_LO)
      rd_word = {8'h00, mac_lo_q};
    else if (I_PADDR == icpf_pkg::OFS_STATUS)
      rd_word = {28'h0, src_q, last_rej_q, last_acc_q, !O_CODE_READY};
    else if (I_PADDR != icpf_pkg::OFS_CTRL)
      addr_bad = 1'b1;
  end

  // answer prepared in setup so the access phase needs no wait
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= I_PWRITE ? 32'h0000_0000 : rd_word;
      err_q <= addr_bad || (I_PWRITE && val_bad);
    end
  end

  // ****************
  // assertions
  // ****************
  logic eval;
  assign eval = state_q == icpf_pkg::ST_EVAL;
  AST_PLEN_MAX: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    plen_q[0] <= icpf_pkg::PLEN_MAX && plen_q[1] <= icpf_pkg::PLEN_MAX)
    else $error("prefix length above sixteen");
  AST_EMPTY_PFX: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    eval && plen_q[src_q] == 5'h00 && !ovf_q && len_q >= LEN_W'(from_q[src_q]) |=> O_ACCEPT)
    else $error("empty prefix code not accepted");
  AST_SHORT_PFX: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    eval && len_q < LEN_W'(plen_q[src_q]) |=> O_REJECT && !O_ACCEPT)
    else $error("code shorter than prefix accepted");
  AST_DFLT_PLEN: assert property (@(posedge I_SYS_CLK)
    $fell(I_RST) |-> plen_q[0] == 5'h00 && plen_q[1] == 5'h00)
    else $error("prefix not empty after reset");
  AST_FROM_RANGE: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    from_q[src_q] >= 6'h01 && from_q[src_q] <= 6'h28)
    else $error("start position out of range");
  AST_SHORT_CODE: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    eval && len_q < LEN_W'(from_q[src_q]) |=> O_REJECT && O_COUNT == 6'h00)
    else $error("code shorter than start accepted");
  AST_DFLT_FROM: assert property (@(posedge I_SYS_CLK)
    $fell(I_RST) |-> from_q[0] == 6'h01 && from_q[1] == 6'h01)
    else $error("start position not one after reset");
  AST_NUM_RANGE: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    num_q[src_q] >= 6'h01 && num_q[src_q] <= 6'h28)
    else $error("length setting out of range");
  AST_CLIP: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    eval && ok && !ovf_q && ({1'b0, from_q[src_q]} + {1'b0, num_q[src_q]} - 7'h01) > 7'(len_q)
    |=> O_COUNT == 6'($past(len_q) - LEN_W'($past(from_q[src_q])) + LEN_W'(1)))
    else $error("clipped count wrong");
  AST_DFLT_NUM: assert property (@(posedge I_SYS_CLK)
    $fell(I_RST) |-> num_q[0] == 6'h28 && num_q[1] == 6'h28)
    else $error("length not forty after reset");
  AST_MAC_EVEN: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !mac_hi_q[icpf_pkg::MAC_LEAD_LSB])
    else $error("odd leading octet stored");
  AST_MAC_RST: assert property (@(posedge I_SYS_CLK)
    $fell(I_RST) |-> O_MAC == FACTORY_MAC)
    else $error("station address not restored");
  AST_PULSE: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (O_ACCEPT || O_REJECT) |-> !(O_ACCEPT && O_REJECT) ##1 !(O_ACCEPT || O_REJECT))
    else $error("result pulse malformed");
endmodule // icpf_top
`default_nettype wire

// >>> bench/icpf_reader_model.sv
// partner model: card reader that streams id-code characters
`timescale 1ns/10ps
`default_nettype none
module icpf_reader_model (
  input wire logic i_clk,
  output logic o_valid,
  output var icpf_pkg::icpf_char_t o_code
);
  // ****************
  // idle lines
  // ****************
  initial
  begin
    o_valid = 1'b0;
    o_code = '0;
  end
  // ****************
  // one code, one char per cycle, source fixed for the whole code
  // ****************
  task automatic send(input logic src, input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_code <= '{src: src, last: (i == s.len() - 1), chr: s[i]};
    end
    @(posedge i_clk);
    o_valid <= 1'b0;
    // released line shows the inverse, so a stale char cannot pass for a fresh one
    o_code.chr <= ~o_code.chr;
  endtask
endmodule // icpf_reader_model
`default_nettype wire

// >>> bench/icpf_tb.sv
// testbench: settings over apb, codes from the reader model, results at the outputs
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [47:0] MAC_F = 48'h0A_00_00_00_00_07; // arbitrary, even lead octet
  localparam logic [7:0] EXT = 8'h20;
  logic clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic code_valid;
  icpf_pkg::icpf_char_t code;
  logic code_ready;
  logic accept;
  logic reject;
  logic src;
  logic [5:0] count;
  logic [icpf_pkg::FIELD_MAX*8-1:0] data;
  logic [47:0] mac;
  logic [31:0] rd;
  logic err;
  int errors;
  int n_compared;
  int cycles;
  icpf_top #(.FACTORY_MAC(MAC_F)) u_icpf_top (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CODE_VALID(code_valid),
    .I_CODE(code), .O_CODE_READY(code_ready), .O_ACCEPT(accept), .O_REJECT(reject),
    .O_SRC(src), .O_COUNT(count), .O_DATA(data), .O_MAC(mac));
  icpf_reader_model u_icpf_reader_model (.i_clk(clk), .o_valid(code_valid), .o_code(code));
  // ****************
  // clock and hang guard
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      print_verdict();
    end
  end
  // ****************
  // compare, apb access, code run
  // ****************
  task automatic check(input logic [319:0] seen, input logic [319:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    check(err, e, "write error flag");
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp, "read data");
    check(err, 1'b0, "read error flag");
  endtask
  task automatic code_chk(input logic s, input string c, input logic ok, input string e);
    logic [319:0] ed;
    int n;
    ed = '0;
    n = 0;
    for (int j = 0; j < e.len(); j++)
      ed[8*j +: 8] = e[j];
    u_icpf_reader_model.send(s, c);
    @(negedge clk);
    check(code_ready, 1'b0, "ready during evaluation");
    do
    begin
      @(negedge clk);
      n++;
    end
    while (accept !== 1'b1 && reject !== 1'b1 && n < 4);
    check(accept, ok, "accept pulse");
    check(reject, !ok, "reject pulse");
    check(src, s, "source");
    check(count, ok ? 6'(e.len()) : 6'h00, "count");
    check(data, ok ? ed : '0, "data");
    @(negedge clk);
    check(accept | reject, 1'b0, "pulse width");
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial
  begin
    errors = 0;
    n_compared = 0;
    cycles = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int b = 0; b < 2; b++)
    begin
      rchk((b == 1 ? EXT : 8'h00) + icpf_pkg::OFS_PLEN, 32'h0000_0000);
      rchk((b == 1 ? EXT : 8'h00) + icpf_pkg::OFS_FROM, 32'h0000_0001);
      rchk((b == 1 ? EXT : 8'h00) + icpf_pkg::OFS_NUM, 32'h0000_0028);
    end
    check(mac, MAC_F, "factory address");
    $display("test defaults done");
    code_chk(1'b0, "12345", 1'b1, "12345");
    code_chk(1'b1, "ABCDEFGHIJKLMNOPQRSTUVWXYZ0123456789abcde", 1'b1,
      "ABCDEFGHIJKLMNOPQRSTUVWXYZ0123456789abcd");
    code_chk(1'b1,
      "012345678901234567890123456789012345678901234567890123456789ABCDE", 1'b0, "");
    $display("test default extraction done");
    wr(icpf_pkg::OFS_PLEN, 32'h0000_0011, 1'b1);
    wr(icpf_pkg::OFS_PLEN, 32'h0000_0010, 1'b0);
    wr(icpf_pkg::OFS_FROM, 32'h0000_0000, 1'b1);
    wr(icpf_pkg::OFS_FROM, 32'h0000_0029, 1'b1);
    wr(icpf_pkg::OFS_FROM, 32'h0000_0028, 1'b0);
    wr(icpf_pkg::OFS_NUM, 32'h0000_0000, 1'b1);
    wr(icpf_pkg::OFS_NUM, 32'h0000_0029, 1'b1);
    wr(icpf_pkg::OFS_NUM, 32'h0000_0001, 1'b0);
    wr(8'h1C, 32'h0000_0001, 1'b1);
    rchk(icpf_pkg::OFS_PLEN, 32'h0000_0010);
    rchk(icpf_pkg::OFS_FROM, 32'h0000_0028);
    rchk(icpf_pkg::OFS_NUM, 32'h0000_0001);
    rchk(EXT + icpf_pkg::OFS_NUM, 32'h0000_0028);
    wr(icpf_pkg::OFS_CTRL, 32'h0000_0001, 1'b0);
    rchk(icpf_pkg::OFS_PLEN, 32'h0000_0000);
    $display("test setting ranges done");
    wr(icpf_pkg::OFS_PLEN, 32'h0000_0003, 1'b0);
    wr(icpf_pkg::OFS_PFX0, 32'h0033_3231, 1'b0);
    wr(icpf_pkg::OFS_PFX3, 32'h4433_2211, 1'b0);
    rchk(icpf_pkg::OFS_PFX0, 32'h0033_3231);
    rchk(icpf_pkg::OFS_PFX3, 32'h4433_2211);
    code_chk(1'b0, "1234", 1'b1, "1234");
    code_chk(1'b0, "123", 1'b1, "123");
    code_chk(1'b0, "14377", 1'b0, "");
    code_chk(1'b0, "12", 1'b0, "");
    code_chk(1'b1, "14377", 1'b1, "14377");
    $display("test prefix done");
    wr(icpf_pkg::OFS_CTRL, 32'h0000_0001, 1'b0);
    wr(icpf_pkg::OFS_FROM, 32'h0000_0003, 1'b0);
    wr(icpf_pkg::OFS_NUM, 32'h0000_0002, 1'b0);
    wr(EXT + icpf_pkg::OFS_FROM, 32'h0000_0002, 1'b0);
    wr(EXT + icpf_pkg::OFS_NUM, 32'h0000_0003, 1'b0);
    code_chk(1'b0, "123456", 1'b1, "34");
    code_chk(1'b0, "123", 1'b1, "3");
    code_chk(1'b0, "12", 1'b0, "");
    code_chk(1'b1, "12345", 1'b1, "234");
    code_chk(1'b1, "123", 1'b1, "23");
    rchk(icpf_pkg::OFS_STATUS, 32'h0000_000A);
    $display("test extraction done");
    wr(icpf_pkg::OFS_MAC_HI, 32'h0001_0203, 1'b1);
    @(negedge clk);
    check(mac, MAC_F, "odd lead octet kept out");
    wr(icpf_pkg::OFS_MAC_HI, 32'h000A_0B0C, 1'b0);
    wr(icpf_pkg::OFS_MAC_LO, 32'h000D_0E0F, 1'b0);
    rchk(icpf_pkg::OFS_MAC_HI, 32'h000A_0B0C);
    @(negedge clk);
    check(mac, 48'h0A0B_0C0D_0E0F, "station address halves");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(mac, MAC_F, "address after reset");
    rchk(icpf_pkg::OFS_FROM, 32'h0000_0001);
    $display("test station address done");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
